// File: rtl/opp_programmer.sv
// Programming and identification sequencer driving a one-time memory.
`include "opp_timing_regs.svh"

module opp_programmer
  import opp_pkg::*;
#(
  parameter int NUM_WORDS    = `OPP_NUM_WORDS,
  parameter int PULSE_CYCLES = `OPP_PW_CYC
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_b,
  input  wire logic                   i_ce,
  input  wire logic                   i_start,
  input  wire logic                   i_id_start,
  output logic                        o_src_req,
  output logic      [`OPP_ADDR_W-1:0] o_src_addr,
  input  wire logic                   i_src_valid,
  input  wire logic [`OPP_DATA_W-1:0] i_src_data,
  output logic                        o_busy,
  output logic                        o_done,
  output logic                        o_pass,
  output logic                        o_fail,
  output logic      [`OPP_ADDR_W-1:0] o_fail_addr,
  output logic      [`OPP_DATA_W-1:0] o_id_maker,
  output logic      [`OPP_DATA_W-1:0] o_id_part,
  output logic      [`OPP_ADDR_W-1:0] o_addr,
  output logic      [`OPP_DATA_W-1:0] o_data_out,
  output logic                        o_data_oe,
  input  wire logic [`OPP_DATA_W-1:0] i_data_in,
  output logic                        o_chip_select_n,
  output logic                        o_output_gate_n,
  output logic                        o_program_strobe_n,
  output logic                        o_vcc_prog_level,
  output logic                        o_vpp_prog_level,
  output logic                        o_id_high_voltage_line
);

  localparam logic [`OPP_ADDR_W-1:0] LAST_ADDR =
    `OPP_ADDR_W'(NUM_WORDS - 1);
  localparam logic [`OPP_TMR_W-1:0] PULSE_LOAD =
    `OPP_TMR_W'(PULSE_CYCLES - 1);
  localparam logic [`OPP_TMR_W-1:0] SETUP_LOAD =
    `OPP_TMR_W'(`OPP_SETUP_CYC - 1);
  localparam logic [`OPP_TMR_W-1:0] READ_LOAD =
    `OPP_TMR_W'(`OPP_TOE_CYC + `OPP_SYNC_STAGES - 1);
  localparam logic [`OPP_TMR_W-1:0] FLOAT_LOAD =
    `OPP_TMR_W'(`OPP_OUTPUT_FLOAT_DELAY_CYC - 1);
  localparam logic [`OPP_RETRY_W-1:0] RETRY_MAX =
    `OPP_RETRY_W'(`OPP_RETRY_MAX);

  opp_state_t                state;
  opp_phase_t                phase;
  logic [`OPP_TMR_W-1:0]     tmr;
  logic [`OPP_RETRY_W-1:0]   retry;
  logic [`OPP_DATA_W-1:0]    word;
  logic [`OPP_DATA_W-1:0]    rd_sync;
  logic                      match;
  logic                      tmr_zero;
  logic                      last;

  opp_sync #(
    .WIDTH (`OPP_DATA_W)
  ) u_data_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_ce    (i_ce),
    .i_async (i_data_in),
    .o_sync  (rd_sync)
  );

  assign tmr_zero = (tmr == '0);
  assign last     = (o_addr == LAST_ADDR);

  // Pin strobes decode directly from the one-hot state.
  assign o_chip_select_n    = !(state == OPP_S_PULSE ||
                                state == OPP_S_READ);
  assign o_output_gate_n    = (state != OPP_S_READ);
  assign o_program_strobe_n = !(state == OPP_S_SETUP ||
                                state == OPP_S_PULSE ||
                                state == OPP_S_HOLD);
  assign o_src_req          = (state == OPP_S_FETCH);
  assign o_src_addr         = o_addr;
  assign o_busy             = (state != OPP_S_IDLE);

  // Sequencer: state, timer, phase, address, retry count and results.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state                  <= OPP_S_IDLE;
      phase                  <= OPP_PH_FIRST;
      tmr                    <= '0;
      retry                  <= '0;
      word                   <= '0;
      match                  <= 1'b0;
      o_addr                 <= '0;
      o_data_out             <= '0;
      o_data_oe              <= 1'b0;
      o_done                 <= 1'b0;
      o_pass                 <= 1'b0;
      o_fail                 <= 1'b0;
      o_fail_addr            <= '0;
      o_id_maker             <= '0;
      o_id_part              <= '0;
      o_vcc_prog_level       <= 1'b0;
      o_vpp_prog_level       <= 1'b0;
      o_id_high_voltage_line <= 1'b0;
    end else if (i_ce) begin
      if (!tmr_zero) begin
        tmr <= tmr - `OPP_TMR_W'(1);
      end
      unique case (state)
        OPP_S_IDLE: begin
          if (i_start) begin
            o_addr           <= '0;
            phase            <= OPP_PH_FIRST;
            retry            <= '0;
            o_vcc_prog_level <= 1'b1;
            o_vpp_prog_level <= 1'b1;
            o_done           <= 1'b0;
            o_pass           <= 1'b0;
            o_fail           <= 1'b0;
            tmr              <= SETUP_LOAD;
            state            <= OPP_S_SETTLE;
          end else if (i_id_start) begin
            o_addr                 <= '0;
            phase                  <= OPP_PH_ID;
            o_id_high_voltage_line <= 1'b1;
            o_done                 <= 1'b0;
            o_pass                 <= 1'b0;
            o_fail                 <= 1'b0;
            tmr                    <= SETUP_LOAD;
            state                  <= OPP_S_SETTLE;
          end
        end
        OPP_S_SETTLE: begin
          if (tmr_zero) begin
            if (phase == OPP_PH_ID) begin
              tmr   <= READ_LOAD;
              state <= OPP_S_READ;
            end else begin
              state <= OPP_S_FETCH;
            end
          end
        end
        OPP_S_FETCH: begin
          if (i_src_valid) begin
            word <= i_src_data;
            if (phase == OPP_PH_FIRST) begin
              o_data_out <= i_src_data;
              o_data_oe  <= 1'b1;
              tmr        <= SETUP_LOAD;
              state      <= OPP_S_SETUP;
            end else begin
              tmr   <= READ_LOAD;
              state <= OPP_S_READ;
            end
          end
        end
        OPP_S_SETUP: begin
          if (tmr_zero) begin
            tmr   <= PULSE_LOAD;
            state <= OPP_S_PULSE;
          end
        end
        OPP_S_PULSE: begin
          if (tmr_zero) begin
            tmr   <= SETUP_LOAD;
            state <= OPP_S_HOLD;
          end
        end
        OPP_S_HOLD: begin
          if (tmr_zero) begin
            o_data_oe <= 1'b0;
            if (phase == OPP_PH_FIRST) begin
              if (last) begin
                o_addr <= '0;
                phase  <= OPP_PH_LOOP;
              end else begin
                o_addr <= o_addr + `OPP_ADDR_W'(1);
              end
              state <= OPP_S_FETCH;
            end else begin
              tmr   <= READ_LOAD;
              state <= OPP_S_READ;
            end
          end
        end
        OPP_S_READ: begin
          if (tmr_zero) begin
            match <= (rd_sync == word);
            if (phase == OPP_PH_ID) begin
              if (o_addr[`OPP_ID_SEL_BIT]) begin
                o_id_part <= {{(`OPP_ID_UPPER_MSB-`OPP_ID_UPPER_LSB+1){1'b0}},
                              rd_sync[`OPP_ID_UPPER_LSB-1:0]};
              end else begin
                o_id_maker <= {{(`OPP_ID_UPPER_MSB-`OPP_ID_UPPER_LSB+1){1'b0}},
                               rd_sync[`OPP_ID_UPPER_LSB-1:0]};
              end
            end
            tmr   <= FLOAT_LOAD;
            state <= OPP_S_FLOAT;
          end
        end
        OPP_S_FLOAT: begin
          if (tmr_zero) begin
            if (phase == OPP_PH_ID) begin
              if (!o_addr[`OPP_ID_SEL_BIT]) begin
                o_addr[`OPP_ID_SEL_BIT] <= 1'b1;
                tmr                     <= SETUP_LOAD;
                state                   <= OPP_S_SETTLE;
              end else begin
                o_addr                 <= '0;
                o_id_high_voltage_line <= 1'b0;
                o_done                 <= 1'b1;
                state                  <= OPP_S_IDLE;
              end
            end else if (!match) begin
              if (phase == OPP_PH_LOOP && retry != RETRY_MAX) begin
                retry      <= retry + `OPP_RETRY_W'(1);
                o_data_out <= word;
                o_data_oe  <= 1'b1;
                tmr        <= SETUP_LOAD;
                state      <= OPP_S_SETUP;
              end else begin
                o_fail_addr      <= o_addr;
                o_fail           <= 1'b1;
                o_done           <= 1'b1;
                o_vcc_prog_level <= 1'b0;
                o_vpp_prog_level <= 1'b0;
                state            <= OPP_S_IDLE;
              end
            end else begin
              retry <= '0;
              if (!last) begin
                o_addr <= o_addr + `OPP_ADDR_W'(1);
                state  <= OPP_S_FETCH;
              end else if (phase == OPP_PH_LOOP) begin
                o_addr           <= '0;
                phase            <= OPP_PH_FINAL;
                o_vcc_prog_level <= 1'b0;
                o_vpp_prog_level <= 1'b0;
                tmr              <= SETUP_LOAD;
                state            <= OPP_S_SETTLE;
              end else begin
                o_pass <= 1'b1;
                o_done <= 1'b1;
                state  <= OPP_S_IDLE;
              end
            end
          end
        end
      endcase
    end
  end

endmodule : opp_programmer

// File: rtl/opp_timing_regs.svh
// Timing, count and field constants for the one-time memory programmer.
`ifndef OPP_TIMING_REGS_SVH
`define OPP_TIMING_REGS_SVH

`define OPP_CLK_PERIOD_NS   8
`define OPP_PW_NS           50000
`define OPP_SETUP_NS        2000
`define OPP_TOE_NS          150
`define OPP_OUTPUT_FLOAT_DELAY_NS         130

`define OPP_PW_CYC    ((`OPP_PW_NS + `OPP_CLK_PERIOD_NS - 1) / `OPP_CLK_PERIOD_NS)
`define OPP_SETUP_CYC ((`OPP_SETUP_NS + `OPP_CLK_PERIOD_NS - 1) / `OPP_CLK_PERIOD_NS)
`define OPP_TOE_CYC   ((`OPP_TOE_NS + `OPP_CLK_PERIOD_NS - 1) / `OPP_CLK_PERIOD_NS)
`define OPP_OUTPUT_FLOAT_DELAY_CYC  ((`OPP_OUTPUT_FLOAT_DELAY_NS + `OPP_CLK_PERIOD_NS - 1) / `OPP_CLK_PERIOD_NS)

`define OPP_SYNC_STAGES     2
`define OPP_RETRY_MAX       10
`define OPP_NUM_WORDS       131072
`define OPP_ADDR_W          17
`define OPP_DATA_W          16
`define OPP_TMR_W           16
`define OPP_RETRY_W         4
`define OPP_ID_SEL_BIT      0
`define OPP_ID_UPPER_MSB    15
`define OPP_ID_UPPER_LSB    8

`endif

// File: rtl/opp_pkg.sv
// Types shared by the one-time memory programmer.
package opp_pkg;

  typedef enum logic [7:0] {
    OPP_S_IDLE   = 8'h01,
    OPP_S_SETTLE = 8'h02,
    OPP_S_FETCH  = 8'h04,
    OPP_S_SETUP  = 8'h08,
    OPP_S_PULSE  = 8'h10,
    OPP_S_HOLD   = 8'h20,
    OPP_S_READ   = 8'h40,
    OPP_S_FLOAT  = 8'h80
  } opp_state_t;

  typedef enum logic [1:0] {
    OPP_PH_FIRST = 2'h0,
    OPP_PH_LOOP  = 2'h1,
    OPP_PH_FINAL = 2'h2,
    OPP_PH_ID    = 2'h3
  } opp_phase_t;

endpackage : opp_pkg

// File: rtl/opp_sync.sv
// Two-stage synchroniser for pin inputs, frozen by the clock enable.
module opp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_ce,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta   <= '0;
      o_sync <= '0;
    end else if (i_ce) begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end

endmodule : opp_sync

// File: verification/opp_programmer_asserts.sv
// Concurrent checks on the programmer's device pins and status.
module opp_programmer_asserts #(
  parameter int PULSE_CYCLES = 6250
) (
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  input wire logic        i_ce,
  input wire logic [16:0] o_addr,
  input wire logic [15:0] o_data_out,
  input wire logic        o_data_oe,
  input wire logic        o_chip_select_n,
  input wire logic        o_output_gate_n,
  input wire logic        o_program_strobe_n,
  input wire logic        o_vcc_prog_level,
  input wire logic        o_vpp_prog_level,
  input wire logic        o_id_high_voltage_line,
  input wire logic [15:0] o_id_maker,
  input wire logic [15:0] o_id_part,
  input wire logic        o_done,
  input wire logic        o_pass,
  input wire logic        o_fail,
  input wire logic        o_busy
);
  int pcnt;
  int gcnt;
  int fcnt;
  wire pulse = !o_chip_select_n && !o_program_strobe_n;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // Counts pulse cycles, read cycles and cycles since the gate rose.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) pcnt <= 0;
    else if (i_ce) pcnt <= pulse ? pcnt + 1 : 0;
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) gcnt <= 0;
    else if (i_ce) gcnt <= !o_output_gate_n ? gcnt + 1 : 0;
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) fcnt <= 100;
    else if (i_ce) fcnt <= !o_output_gate_n ? 0 : fcnt + 1;
  end
  property p_pulse_len;
    $rose(o_chip_select_n) && !o_program_strobe_n |-> pcnt == PULSE_CYCLES;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse width");
  property p_pulse_sup; pulse |-> o_vcc_prog_level && o_vpp_prog_level;
  endproperty
  a_pulse_sup: assert property (p_pulse_sup) else $error("supply");
  property p_pulse_data;
    pulse |-> o_output_gate_n && o_data_oe && $stable(o_data_out);
  endproperty
  a_pulse_data: assert property (p_pulse_data) else $error("data");
  property p_read_len; $rose(o_output_gate_n) |-> gcnt == 21; endproperty
  a_read_len: assert property (p_read_len) else $error("read wait");
  property p_float; $rose(o_data_oe) |-> fcnt >= 17; endproperty
  a_float: assert property (p_float) else $error("float wait");
  property p_id_addr; o_id_high_voltage_line |-> o_addr[16:1] == 16'h0000;
  endproperty
  a_id_addr: assert property (p_id_addr) else $error("id address");
  property p_id_upper; o_id_maker[15:8] == 8'h00 && o_id_part[15:8] == 8'h00;
  endproperty
  a_id_upper: assert property (p_id_upper) else $error("id upper");
  property p_done; o_done |-> !o_busy && !(o_pass && o_fail); endproperty
  a_done: assert property (p_done) else $error("status");
  property p_start_addr; $rose(o_busy) |-> o_addr == 17'h00000; endproperty
  a_start_addr: assert property (p_start_addr) else $error("start");
endmodule : opp_programmer_asserts

bind opp_programmer opp_programmer_asserts #(
  .PULSE_CYCLES(PULSE_CYCLES)
) u_chk (.i_clk, .i_rst_b, .i_ce, .o_addr, .o_data_out, .o_data_oe,
  .o_chip_select_n, .o_output_gate_n, .o_program_strobe_n,
  .o_vcc_prog_level, .o_vpp_prog_level, .o_id_high_voltage_line,
  .o_id_maker, .o_id_part, .o_done, .o_pass, .o_fail, .o_busy);

// File: verification/opp_otp_model.sv
// Behavioural one-time memory answering the programmer's pins.
module opp_otp_model #(
  parameter int          NW    = 4,
  parameter int          DLY   = 140,
  parameter logic [15:0] MAKER = 16'h005A, // Arbitrary value.
  parameter logic [15:0] PART  = 16'h00C3  // Arbitrary value.
) (
  input  wire logic        i_wipe,
  input  wire logic [16:0] i_weak_addr,
  input  wire logic [4:0]  i_weak_n,
  input  wire logic [16:0] i_addr,
  input  wire logic [15:0] i_data,
  input  wire logic        i_chip_select_n,
  input  wire logic        i_output_gate_n,
  input  wire logic        i_program_strobe_n,
  input  wire logic        i_vcc_prog,
  input  wire logic        i_vpp_prog,
  input  wire logic        i_id_line,
  output logic      [15:0] o_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [NW];
  logic [4:0]  cnt [NW];
  logic [15:0] last = 16'h0000;
  wire rd = !i_chip_select_n && !i_output_gate_n && i_program_strobe_n;
  always @(posedge i_wipe) begin
    for (int i = 0; i < NW; i++) begin
      mem[i] = 16'hFFFF;
      cnt[i] = 5'h00;
    end
  end
  // A word takes its data once it has seen its needed pulse count.
  always @(posedge i_chip_select_n) begin
    if (!i_program_strobe_n && i_output_gate_n && i_vcc_prog && i_vpp_prog
        && i_addr < NW) begin
      cnt[i_addr] = cnt[i_addr] + 5'h01;
      if (cnt[i_addr] >= ((i_addr == i_weak_addr) ? i_weak_n : 5'h01)) begin
        mem[i_addr] = i_data;
      end
    end
  end
  always @* begin
    if (rd) last = i_id_line ? (i_addr[0] ? PART : MAKER) : mem[i_addr];
  end
  assign #(DLY) o_q = rd ? last : ~last;
endmodule : opp_otp_model

// File: verification/tb.sv
// Self-checking bench for the one-time memory programmer.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NW = 4;
  logic clk, rst_b, start, id_start, src_valid, wipe, ce;
  logic [15:0] src_data;
  logic [16:0] weak_a;
  logic [4:0]  weak_n;
  wire src_req, busy, done, pass, fail, data_oe, cs_n, og_n, pg_n;
  wire vcc, vpp, idl;
  wire [16:0] src_addr, fail_addr, addr;
  wire [15:0] id_maker, id_part, data_out, dev_q, data_in;
  int error_cnt, compares;
  opp_programmer #(.NUM_WORDS(NW), .PULSE_CYCLES(8)) uut (
    .i_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .i_start(start),
    .i_id_start(id_start), .o_src_req(src_req), .o_src_addr(src_addr),
    .i_src_valid(src_valid), .i_src_data(src_data), .o_busy(busy),
    .o_done(done), .o_pass(pass), .o_fail(fail), .o_fail_addr(fail_addr),
    .o_id_maker(id_maker), .o_id_part(id_part), .o_addr(addr),
    .o_data_out(data_out), .o_data_oe(data_oe), .i_data_in(data_in),
    .o_chip_select_n(cs_n), .o_output_gate_n(og_n),
    .o_program_strobe_n(pg_n), .o_vcc_prog_level(vcc),
    .o_vpp_prog_level(vpp), .o_id_high_voltage_line(idl));
  opp_otp_model #(.NW(NW)) dev (
    .i_wipe(wipe), .i_weak_addr(weak_a), .i_weak_n(weak_n), .i_addr(addr),
    .i_data(data_out), .i_chip_select_n(cs_n), .i_output_gate_n(og_n),
    .i_program_strobe_n(pg_n), .i_vcc_prog(vcc), .i_vpp_prog(vpp),
    .i_id_line(idl), .o_q(dev_q));
  assign data_in = data_oe ? data_out : dev_q;
  function automatic logic [15:0] pat(input logic [16:0] a);
    return 16'h5AC3 ^ a[15:0];
  endfunction : pat
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    src_valid <= src_req && !src_valid;
    src_data <= pat(src_addr);
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic wait_done;
    int n;
    n = 0;
    @(negedge clk);
    while (done !== 1'b1 && n < 40000) begin
      @(negedge clk);
      n++;
    end
    chk(busy, 0);
    chk(done, 1);
  endtask : wait_done
  // A start seen while the clock enable is low must not launch a run.
  task automatic frozen_start;
    @(posedge clk);
    ce <= 1'b0;
    start <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk(busy, 0);
    @(posedge clk);
    ce <= 1'b1;
    start <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk(busy, 0);
  endtask : frozen_start
  task automatic prog(input logic [16:0] wa, input logic [4:0] wn,
                      input logic ep);
    @(posedge clk);
    weak_a <= wa;
    weak_n <= wn;
    wipe <= 1'b1;
    start <= 1'b1;
    @(posedge clk);
    wipe <= 1'b0;
    start <= 1'b0;
    wait_done();
    chk(pass, ep);
    chk(fail, !ep);
    chk(vpp, 0);
    chk(vcc, 0);
    chk(dev.cnt[wa], ep ? wn : 5'h0B);
    if (!ep) chk(fail_addr, wa);
    else for (int i = 0; i < NW; i++) chk(dev.mem[i], pat(i));
  endtask : prog
  task automatic id_read;
    @(posedge clk);
    id_start <= 1'b1;
    @(posedge clk);
    id_start <= 1'b0;
    wait_done();
    chk(id_maker, 16'h005A);
    chk(id_part, 16'h00C3);
    chk({pass, fail}, 0);
  endtask : id_read
  initial begin
    error_cnt = 0;
    compares = 0;
    rst_b = 1'b0;
    start = 1'b0;
    id_start = 1'b0;
    ce = 1'b1;
    wipe = 1'b0;
    weak_a = 17'h00000;
    weak_n = 5'h01;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    frozen_start();
    prog(17'h00000, 5'h01, 1'b1);
    prog(17'h00003, 5'h0B, 1'b1);
    prog(17'h00001, 5'h0C, 1'b0);
    id_read();
    summarize();
  end
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    summarize();
  end
endmodule : tb
